// file: inc/tlv_pkg.sv
/*
  Shared constants and types for the two-level vectored interrupt unit.
  Assumes one system clock and a byte-wide special-function register port.
*/
package tlv_pkg;
  // ==========================================================
  // Sources and slots
  localparam int           TLV_NUM_SLOTS     = 17;
  localparam int           TLV_SLOT_W        = 5;
  localparam int           TLV_TIMER2_SLOT   = 5;
  localparam int           TLV_RESERVED_SLOT = 13;
  localparam logic [16:0]  TLV_SLOT_USED     = 17'h1dfff;
  localparam logic [16:0]  TLV_HW_CLEAR      = 17'h0000f;
  localparam logic [16:0]  TLV_PRIO_RESET    = 17'h00000;

  // ==========================================================
  // Enable register
  localparam logic [7:0]   TLV_IE_ADDR       = 8'ha8;
  localparam logic [7:0]   TLV_IE_RESET      = 8'h00;
  localparam int           TLV_GLOBAL_BIT    = 7;
  localparam int           TLV_LOCAL_BITS    = 7;

  // ==========================================================
  // Vector layout
  localparam logic [15:0]  TLV_RESET_VECTOR  = 16'h0000;
  localparam logic [15:0]  TLV_VEC_BASE      = 16'h0003;
  localparam int           TLV_VEC_SHIFT     = 3;

  // ==========================================================
  // Response timing in system clocks
  localparam int           TLV_DETECT_CYCLES = 1;
  localparam int           TLV_CALL_CYCLES   = 4;
  localparam int           TLV_BEST_LATENCY  = TLV_DETECT_CYCLES + TLV_CALL_CYCLES;
  localparam int           TLV_WORST_LATENCY = 18;

  // ==========================================================
  // Types
  typedef enum logic {
    TLV_GATE_OPEN,
    TLV_GATE_AFTER_RETURN
  } tlv_gate_t;

  typedef struct packed {
    logic                  valid;
    logic                  high;
    logic [TLV_SLOT_W-1:0] slot;
    logic [15:0]           vector;
  } tlv_req_t;
endpackage

// file: logic/tlv_irq_unit.sv
/*
  Two-level vectored interrupt unit: enable register, priority resolve,
  nesting track and long-call request towards the core.
  Assumes pending flags, priority bits and extended enables come from
  logic on sys_clk, and that the core reports take, return and
  instruction completion as one-cycle strobes.
*/
// Functional notes
// [R1] Up to 16 sources; software-set pending flags request exactly like hardware events.
// [R2] Each source low or high; low routine preemptible by high, high never.
// [R3] All priority settings read as low after reset.
// [R4] Simultaneous requests: high before low, then smallest order number wins.
// [R5] All pending requests sampled and priority decoded every system clock.
// [R6] Best case five clocks: one detect, four for the long call.
// [R7] Pending at return: exactly one further instruction before the long call.
// [R8] Worst case eighteen clocks: detect, return, divide, long call.
// [R9] Equal or higher routine running holds requests until return plus one instruction.
// [R10] Reset vector 0x0000; order n at 0x0003 plus 8n; slot 13 reserved.
// [R11] Global enable bit 7 gates every source; zero blocks all requests.
// [R12] Enable bits 6..0 mask SPI, timer 2, UART, timer 1, ext 1, timer 0, ext 0.
// [R13] Timer 2 enable covers both low-byte and high-byte overflow flags.
// [R14] Enable register at 0xA8, all pages, bit addressable, resets to zero.
// [R15] Pending flags set regardless of enables; disabled flags are ignored.
// [R16] Some flags hardware-cleared on vectoring; still-set flag re-requests after return.
// [R17] One in-service marker per level, set on take, cleared on return.
// [R18] Core strobes request-taken at long call start and return-done at return end.
`timescale 1ns/10ps
module tlv_irq_unit
  import tlv_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  input  wire logic [7:0]              sfr_addr,
  input  wire logic                    sfr_wr,
  input  wire logic [7:0]              sfr_wdata,
  input  wire logic                    sfr_bit_wr,
  input  wire logic [2:0]              sfr_bit_sel,
  input  wire logic                    sfr_bit_val,
  input  wire logic                    sfr_rd,
  output logic      [7:0]              sfr_rdata,
  input  wire logic [TLV_NUM_SLOTS-1:0] src_pending,
  input  wire logic                    timer2_low_overflow_flag,
  input  wire logic                    timer2_high_overflow_flag,
  input  wire logic [TLV_NUM_SLOTS-1:0] src_prio_high,
  input  wire logic [TLV_NUM_SLOTS-1:0] ext_src_enable,
  input  wire logic                    core_take,
  input  wire logic                    core_return_done,
  input  wire logic                    core_instr_done,
  output tlv_req_t                     core_req,
  output logic [TLV_NUM_SLOTS-1:0]     flag_hw_clear,
  output logic [1:0]                   in_service
);

  // ==========================================================
  // Helper functions
  // Lowest set index; decoder used for both levels
  function automatic logic [TLV_SLOT_W-1:0] first_slot(input logic [TLV_NUM_SLOTS-1:0] v);
    logic [TLV_SLOT_W-1:0] idx;
    idx = '0;
    for (int i = TLV_NUM_SLOTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = TLV_SLOT_W'(i);
      end
    end
    return idx;
  endfunction

  // Vector address of an order number, 8 bytes per slot
  function automatic logic [15:0] slot_vector(input logic [TLV_SLOT_W-1:0] s);
    return TLV_VEC_BASE + (16'(s) << TLV_VEC_SHIFT);
  endfunction

  // ==========================================================
  // Enable register
  logic [7:0]              ie_q;
  logic [7:0]              ie_d;
  logic [7:0]              ie_bit_mask;
  logic                    ie_hit;
  logic [7:0]              rdata_q;
  logic [TLV_NUM_SLOTS-1:0] prio_q;

  assign ie_hit      = (sfr_addr == TLV_IE_ADDR);                   // [R14]
  assign ie_bit_mask = 8'h01 << sfr_bit_sel;
  // Byte write wins over a bit write in the same cycle
  assign ie_d = (ie_hit && sfr_wr)     ? sfr_wdata :
                (ie_hit && sfr_bit_wr) ? ((ie_q & ~ie_bit_mask) |
                                          ({8{sfr_bit_val}} & ie_bit_mask)) :
                ie_q;                                               // [R14]

  // Register state and the read data flop
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ie_q    <= TLV_IE_RESET;                                      // [R14]
      rdata_q <= 8'h00;
    end else begin
      ie_q    <= ie_d;
      if (sfr_rd) begin
        rdata_q <= ie_hit ? ie_q : 8'h00;
      end
    end
  end
  assign sfr_rdata = rdata_q;

  // Priority bits are held here so they read low from reset onward
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prio_q <= TLV_PRIO_RESET;                                     // [R3]
    end else begin
      prio_q <= src_prio_high & TLV_SLOT_USED;
    end
  end

  // ==========================================================
  // Request qualification
  logic [TLV_NUM_SLOTS-1:0] flags;
  logic [TLV_NUM_SLOTS-1:0] local_en;
  logic [TLV_NUM_SLOTS-1:0] armed;
  logic [TLV_NUM_SLOTS-1:0] armed_high;
  logic [TLV_NUM_SLOTS-1:0] armed_low;

  // Timer 2 has two flags behind one enable
  always_comb begin
    flags = src_pending;
    flags[TLV_TIMER2_SLOT] = src_pending[TLV_TIMER2_SLOT] | timer2_low_overflow_flag |
                             timer2_high_overflow_flag;             // [R13]
  end
  assign local_en = {ext_src_enable[TLV_NUM_SLOTS-1:TLV_LOCAL_BITS],
                     ie_q[TLV_LOCAL_BITS-1:0]};                     // [R12]
  // Flags are seen only while both enables are on; reserved slot never
  assign armed = flags & local_en & TLV_SLOT_USED &
                 {TLV_NUM_SLOTS{ie_q[TLV_GLOBAL_BIT]}};             // [R1] [R11] [R15]
  assign armed_high = armed & prio_q;
  assign armed_low  = armed & ~prio_q;

  // ==========================================================
  // Nesting and return hold-off
  logic [1:0]  insvc_q;
  tlv_gate_t   gate_q;
  tlv_gate_t   gate_d;
  logic        hold_off;
  logic        allow_high;
  logic        allow_low;
  logic        pick_high;
  logic        pick_any;
  logic [TLV_SLOT_W-1:0] pick_slot;

  // After a return one instruction must finish before the next call
  always_comb begin
    gate_d = gate_q;
    unique case (gate_q)
      TLV_GATE_OPEN: begin
        if (core_return_done) begin
          gate_d = TLV_GATE_AFTER_RETURN;                           // [R7] [R9]
        end
      end
      TLV_GATE_AFTER_RETURN: begin
        if (core_instr_done) begin
          gate_d = TLV_GATE_OPEN;                                   // [R7]
        end
      end
    endcase
  end

  // The return strobe itself also blocks, so no call slips in under it
  assign hold_off   = (gate_q == TLV_GATE_AFTER_RETURN) || core_return_done;   // [R9]
  assign allow_high = !insvc_q[1] && !hold_off;                     // [R2]
  assign allow_low  = !insvc_q[1] && !insvc_q[0] && !hold_off;      // [R2] [R9]
  assign pick_high  = allow_high && (armed_high != '0);             // [R4]
  assign pick_any   = pick_high || (allow_low && (armed_low != '0));
  assign pick_slot  = pick_high ? first_slot(armed_high) : first_slot(armed_low); // [R4]

  // Markers: take sets the level, return clears the innermost one
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      insvc_q <= 2'b00;
      gate_q  <= TLV_GATE_OPEN;
    end else begin
      gate_q <= gate_d;
      // Return first and take last, so a take landing with a return keeps its marker
      if (core_return_done) begin
        if (insvc_q[1]) begin
          insvc_q[1] <= 1'b0;                                       // [R17]
        end else begin
          insvc_q[0] <= 1'b0;                                       // [R17]
        end
      end
      if (core_take && core_req.valid) begin
        insvc_q[core_req.high] <= 1'b1;                             // [R17] [R18]
      end
    end
  end
  assign in_service = insvc_q;

  // ==========================================================
  // Request to the core, decoded every clock
  tlv_req_t                req_q;
  logic [TLV_NUM_SLOTS-1:0] clear_q;

  // One clock of detection; the core spends the next four on the call
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      req_q   <= '{valid: 1'b0, high: 1'b0, slot: '0, vector: TLV_RESET_VECTOR};
      clear_q <= '0;
    end else begin
      req_q.valid  <= pick_any && !core_take;                       // [R5] [R6] [R8]
      req_q.high   <= pick_high;
      req_q.slot   <= pick_slot;
      req_q.vector <= slot_vector(pick_slot);                       // [R10]
      // Only the auto-cleared flags get a clear pulse when vectoring
      clear_q      <= (core_take && req_q.valid) ?
                      (TLV_HW_CLEAR & (17'h00001 << req_q.slot)) : '0;   // [R16]
    end
  end
  assign core_req      = req_q;
  assign flag_hw_clear = clear_q;

  // ==========================================================
  // Checks
  // Enable register: reset value, byte writes and read data
  a_ie_reset_zero: assert property (@(posedge sys_clk) // [R14]
    reset |=> ie_q == TLV_IE_RESET)
    else $error("enable register not zero after reset");

  a_byte_write: assert property (@(posedge sys_clk) disable iff (reset) // [R14]
    (ie_hit && sfr_wr) |=> (ie_q == $past(sfr_wdata)))
    else $error("byte write did not land in enable register");

  a_read_data: assert property (@(posedge sys_clk) disable iff (reset) // [R14]
    (ie_hit && sfr_rd) |=> (sfr_rdata == $past(ie_q)))
    else $error("read data does not match enable register");

  // Gating: a request needs the global bit and, for low slots, its own bit
  a_global_gate_off: assert property (@(posedge sys_clk) disable iff (reset) // [R11]
    !ie_q[TLV_GLOBAL_BIT] |=> !core_req.valid)
    else $error("request raised while global enable off");

  a_enable_masks: assert property (@(posedge sys_clk) disable iff (reset) // [R12] [R15]
    (core_req.valid && core_req.slot < TLV_SLOT_W'(TLV_LOCAL_BITS)) |->
      ($past(ie_q[TLV_GLOBAL_BIT]) && (($past(ie_q) >> core_req.slot[2:0]) & 8'h01) != 8'h00))
    else $error("request from a source whose enable was off");

  // Levels and nesting
  a_high_not_preempted: assert property (@(posedge sys_clk) disable iff (reset) // [R2]
    insvc_q[1] |=> !core_req.valid)
    else $error("request during high level routine");

  a_low_only_by_high: assert property (@(posedge sys_clk) disable iff (reset) // [R2] [R9]
    (insvc_q == 2'b01) |=> (!core_req.valid || core_req.high))
    else $error("low request preempted a low routine");

  a_detect_one_clock: assert property (@(posedge sys_clk) disable iff (reset) // [R5] [R6]
    (armed_high != '0 && !insvc_q[1] && gate_q == TLV_GATE_OPEN &&
     !core_return_done && !core_take) |=> (core_req.valid && core_req.high))
    else $error("armed high request not raised next clock");

  a_return_holdoff: assert property (@(posedge sys_clk) disable iff (reset) // [R7]
    (core_return_done && !core_instr_done) ##1 !core_instr_done |=> !core_req.valid)
    else $error("call requested before instruction after return");

  a_gate_opens: assert property (@(posedge sys_clk) disable iff (reset) // [R7]
    (gate_q == TLV_GATE_AFTER_RETURN && core_instr_done) |=> (gate_q == TLV_GATE_OPEN))
    else $error("hold-off not released after one instruction");

  a_vector_map: assert property (@(posedge sys_clk) disable iff (reset) // [R10]
    core_req.valid |-> (core_req.vector == TLV_VEC_BASE + 16'(core_req.slot) * 16'h0008 &&
                        core_req.slot != TLV_SLOT_W'(TLV_RESERVED_SLOT)))
    else $error("vector does not match slot");

  a_high_first: assert property (@(posedge sys_clk) disable iff (reset) // [R4]
    (core_req.valid && !core_req.high) |-> ($past(armed_high) == '0 || $past(insvc_q[1])))
    else $error("low request chosen over high");

  // Markers follow the core strobes
  a_marker_set: assert property (@(posedge sys_clk) disable iff (reset) // [R17]
    (core_take && core_req.valid && core_req.high) |=> insvc_q[1])
    else $error("high marker not set on take");

  a_low_marker_set: assert property (@(posedge sys_clk) disable iff (reset) // [R17]
    (core_take && core_req.valid && !core_req.high) |=> insvc_q[0])
    else $error("low marker not set on take");

  a_return_clears: assert property (@(posedge sys_clk) disable iff (reset) // [R17]
    (core_return_done && !core_take && insvc_q[1]) |=> !insvc_q[1])
    else $error("high marker not cleared on return");

  a_valid_drops: assert property (@(posedge sys_clk) disable iff (reset) // [R18]
    core_take |=> !core_req.valid)
    else $error("request still raised after take");

  // Hardware clears only follow a take, and only for the auto-cleared slots
  a_clear_on_take: assert property (@(posedge sys_clk) disable iff (reset) // [R16]
    (core_take && core_req.valid) |=>
      (flag_hw_clear == (TLV_HW_CLEAR & (17'h00001 << $past(core_req.slot)))))
    else $error("clear pulse does not match taken slot");

  a_clear_only_take: assert property (@(posedge sys_clk) disable iff (reset) // [R16]
    (flag_hw_clear != '0) |-> ($past(core_take) && $past(core_req.valid)))
    else $error("clear pulse without a take");

  a_prio_reset_low: assert property (@(posedge sys_clk) // [R3]
    reset |=> prio_q == TLV_PRIO_RESET)
    else $error("priority not low after reset");

endmodule

// file: testbench/test_two_level_vectored_interrupt_unit.sv
/*
  Bench for tlv_irq_unit: enable register, decode, latency and nesting.
  Assumes tlv_core_model plays the core on one 100 MHz clock.
*/
`timescale 1ns/10ps
module test_two_level_vectored_interrupt_unit
  import tlv_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        reset, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, t2_low, t2_high, do_return;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
  logic [2:0]  sfr_bit_sel;
  logic [16:0] src_pending, src_prio_high, ext_src_enable, flag_hw_clear;
  logic [16:0] clr_seen = 17'h00000;
  logic [1:0]  in_service;
  logic [3:0]  take_wait, instr_len;
  logic        core_take, core_return_done, core_instr_done;
  tlv_req_t    core_req;
  int          err_count = 0;
  int          num_checks = 0;

  tlv_irq_unit dut (.sys_clk, .reset, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_bit_wr,
    .sfr_bit_sel, .sfr_bit_val, .sfr_rd, .sfr_rdata, .src_pending,
    .timer2_low_overflow_flag(t2_low), .timer2_high_overflow_flag(t2_high), .src_prio_high,
    .ext_src_enable, .core_take, .core_return_done, .core_instr_done, .core_req,
    .flag_hw_clear, .in_service);
  tlv_core_model core (.sys_clk, .reset, .core_req, .take_wait, .do_return, .instr_len,
    .core_take, .core_return_done, .core_instr_done);

  // ==========================================================
  // Clock and clear-pulse collector
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (!reset) clr_seen <= clr_seen | flag_hw_clear;

  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Kind 0 byte write, 1 bit write ({val,sel} in d), 2 read expecting d
  task automatic special_function_register(input int kind, input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    sfr_addr    <= a;
    sfr_wdata   <= d;
    sfr_bit_sel <= d[2:0];
    sfr_bit_val <= d[3];
    sfr_wr      <= kind == 0;
    sfr_bit_wr  <= kind == 1;
    sfr_rd      <= kind == 2;
    cyc(1);
    {sfr_wr, sfr_bit_wr, sfr_rd} <= 3'h0;
    #1;
    if (kind == 2) check("sfr_rdata", 24'(sfr_rdata), 24'(d));
  endtask
  // Pend and prio are driven together; the three-clock wait covers the extra flop on prio inside
  task automatic expect_req(input logic [16:0] pend, input logic [16:0] prio,
                            input logic v, input logic [4:0] s);
    cyc(1);
    src_pending   <= pend;
    src_prio_high <= prio;
    cyc(3);
    #1;
    check("req_valid", 24'(core_req.valid), 24'(v));
    if (v) check("req_vector", 24'({core_req.high, core_req.slot, core_req.vector}),
                 24'({prio[s], s, 16'h0003 + {8'h00, s, 3'h0}}));
  endtask
  task automatic wait_take(input int n);
    int i;
    // Sampled 1 ns after the edge, once the strobe has settled
    for (i = 0; i < n && core_take !== 1'b1; i++) begin
      cyc(1);
      #1;
    end
    if (core_take !== 1'b1) begin
      err_count++;
      $display("[ERR] core_take expected 1 seen 0");
      final_report();
    end
  endtask
  task automatic ret();
    cyc(1);
    do_return <= 1'b1;
    cyc(1);
    do_return <= 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    {sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, t2_low, t2_high, do_return} = 7'h00;
    {sfr_addr, sfr_wdata, sfr_bit_sel} = 19'h00000;
    {src_pending, src_prio_high, ext_src_enable} = 51'h0;
    take_wait = 4'hf;
    instr_len = 4'h8;
    cyc(4);
    reset <= 1'b0;
    #1;
    check("reset_state", 24'({core_req.valid, core_req.vector, in_service}), 24'h0);
    special_function_register(2, 8'ha8, 8'h00);
    special_function_register(0, 8'ha8, 8'h7f);
    special_function_register(2, 8'ha8, 8'h7f);
    special_function_register(1, 8'ha8, 8'h0f);
    special_function_register(1, 8'ha8, 8'h03);
    special_function_register(2, 8'ha8, 8'hf7);
    special_function_register(0, 8'ha9, 8'h00);
    special_function_register(2, 8'ha9, 8'h00);
    special_function_register(2, 8'ha8, 8'hf7);
    $display("test registers done");
    special_function_register(0, 8'ha8, 8'h7f);
    expect_req(17'h00001, 17'h0, 1'b0, 5'd0);
    special_function_register(1, 8'ha8, 8'h0f);
    expect_req(17'h00001, 17'h0, 1'b1, 5'd0);
    for (int b = 0; b < 7; b++) begin
      special_function_register(0, 8'ha8, 8'h80 | (8'h01 << b));
      expect_req(17'h0007f, 17'h0, 1'b1, 5'(b));
    end
    special_function_register(0, 8'ha8, 8'hff);
    expect_req(17'h0007f, 17'h0, 1'b1, 5'd0);
    expect_req(17'h0007f, 17'h00040, 1'b1, 5'd6);
    special_function_register(0, 8'ha8, 8'ha0);
    cyc(1);
    t2_high <= 1'b1;
    expect_req(17'h0, 17'h0, 1'b1, 5'd5);
    cyc(1);
    {t2_high, t2_low} <= 2'b01;
    expect_req(17'h0, 17'h0, 1'b1, 5'd5);
    cyc(1);
    t2_low <= 1'b0;
    ext_src_enable <= 17'h1ff80;
    special_function_register(0, 8'ha8, 8'h80);
    expect_req(17'h14000, 17'h0, 1'b1, 5'd14);
    expect_req(17'h02000, 17'h0, 1'b0, 5'd0);
    expect_req(17'h10000, 17'h0, 1'b1, 5'd16);
    $display("test decode done");
    special_function_register(0, 8'ha8, 8'h83);
    cyc(1);
    ext_src_enable <= 17'h0;
    src_pending <= 17'h0;
    cyc(2);
    take_wait <= 4'h0;
    src_pending <= 17'h00002;
    cyc(1);
    #1;
    check("detect", 24'(core_req.valid), 24'h1);
    wait_take(TLV_CALL_CYCLES);
    expect_req(17'h00001, 17'h0, 1'b0, 5'd0);
    check("low_active", 24'(in_service), 24'h1);
    check("hw_clear", 24'(clr_seen), 24'h2);
    // A high request preempts the low routine, then nothing preempts it
    expect_req(17'h00003, 17'h00002, 1'b1, 5'd1);
    wait_take(TLV_CALL_CYCLES);
    cyc(2);
    #1;
    check("both_active", 24'(in_service), 24'h3);
    check("high_unpreempted", 24'(core_req.valid), 24'h0);
    ret();
    for (int i = 0; i < 6; i++) begin
      cyc(1);
      #1;
      check("held_after_return", 24'(core_req.valid), 24'h0);
    end
    check("high_cleared", 24'(in_service), 24'h1);
    wait_take(TLV_WORST_LATENCY);
    cyc(2);
    src_pending <= 17'h0;
    ret();
    cyc(12);
    check("after_first_ret", 24'(in_service), 24'h1);
    ret();
    cyc(12);
    check("after_second_ret", 24'(in_service), 24'h0);
    $display("test nesting done");
    final_report();
  end
endmodule

// file: testbench/tlv_core_model.sv
/*
  Core model for the interrupt unit: takes vector calls and reports returns.
  Assumes tlv_irq_unit drives core_req on sys_clk and the bench commands returns.
*/
`timescale 1ns/10ps
module tlv_core_model
  import tlv_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire tlv_req_t   core_req,
  input  wire logic [3:0] take_wait,
  input  wire logic       do_return,
  input  wire logic [3:0] instr_len,
  output logic            core_take,
  output logic            core_return_done,
  output logic            core_instr_done
);
  logic [3:0] wait_q;
  logic [3:0] run_q;

  // ==========================================================
  // Strobes towards the unit; take_wait of f stalls the core for good
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      core_take        <= 1'b0;
      core_return_done <= 1'b0;
      core_instr_done  <= 1'b0;
      wait_q           <= 4'h0;
      run_q            <= 4'h0;
    end else begin
      wait_q           <= (core_req.valid && !core_take) ? wait_q + 4'h1 : 4'h0;
      core_take        <= core_req.valid && !core_take && wait_q == take_wait
                          && take_wait != 4'hf;
      core_return_done <= do_return;
      // One instruction of instr_len clocks follows every return
      run_q            <= do_return ? instr_len : (run_q != 4'h0 ? run_q - 4'h1 : 4'h0);
      core_instr_done  <= run_q == 4'h1;
    end
  end
endmodule
